// File: cycle_timer.sv
// Purpose: Down-counting delay timer for the DRAM sequencer.
// Assumes: load_i and a nonzero count start a wait; done_o is a level.
// Notes:   A count of zero is treated as one cycle.
module cycle_timer
  import dram_ctrl_pkg::*;
#(
  parameter int unsigned WIDTH = TIMER_W
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] count_i,
  output logic                  done_o
);

  initial begin
    if (WIDTH < 8) $error("cycle_timer WIDTH too small");
  end

  logic [WIDTH-1:0] remain;

  // ----------------------------------------------------------------
  // Countdown
  // ----------------------------------------------------------------
  // Loading count-1 lets done rise exactly count cycles after load
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain <= '0;
    end else if (load_i) begin
      remain <= (count_i == '0) ? '0 : count_i - 1'b1;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end

  assign done_o = (remain == '0) && !load_i;

endmodule

// File: dram_ctrl.sv
// Purpose: Controller for a 1M x 1 asynchronous DRAM: init, refresh, access.
// Assumes: 100 MHz clock; the memory is on the pins below, data-in and
//          data-out on separate pins (or joined, when only early writes used).
// Notes:   Writes are always early writes, so data-out never fights data-in.
//          Reads also wait out the two-stage synchroniser on data-out, so a
//          read ends a little later than the access time alone would need.
module dram_ctrl
  import dram_ctrl_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned REFRESH_CYCLES = REFRESH_SLOT_CYC,
  parameter bit          USE_CBR        = 1'b1
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic              req_wdata_i,
  output logic                   rsp_valid_o,
  output logic                   rsp_rdata_o,
  output logic                   init_done_o,
  output logic                   row_strobe_n_o,
  output logic                   col_strobe_n_o,
  output logic                   write_strobe_n_o,
  output logic [PIN_W-1:0]       multiplexed_address_pins_o,
  output logic                   data_in_o,
  input  wire logic              data_out_i
);

  initial begin
    if (POWERUP_CYCLES < 1 || POWERUP_CYCLES > 65535) $error("POWERUP_CYCLES out of range");
    if (REFRESH_CYCLES < 64 || REFRESH_CYCLES > 65535) $error("REFRESH_CYCLES out of range");
    // Every wait handed to the shared timer must fit its count width
    if (ROW_PULSE_CYC >= 2**TIMER_W || PRECHARGE_CYC >= 2**TIMER_W) $error("row timing exceeds timer width");
    if (READ_WAIT_CYC >= 2**TIMER_W || COL_PRE_CYC >= 2**TIMER_W) $error("column timing exceeds timer width");
    // A slot shorter than one access plus one refresh would let refresh lag
    if (REFRESH_CYCLES < 2 * (ROW_PULSE_CYC + PRECHARGE_CYC) + READ_WAIT_CYC + 16) $error("refresh slot too short");
  end

  // Sequencer states: one access or one refresh at a time, each ending in a
  // full row precharge. The shared timer paces every step but the one-cycle
  // ST_ROW, so a timed state waits for timer_done with no load pending before it moves on.
  typedef enum logic [3:0] {
    ST_POWERUP  = 4'h0,
    ST_IDLE     = 4'h1,
    ST_ROW      = 4'h2,
    ST_COL      = 4'h3,
    ST_ACCESS   = 4'h4,
    ST_COL_PRE  = 4'h5,
    ST_PRECHG   = 4'h6,
    ST_RF_CAS   = 4'h7,
    ST_RF_RAS   = 4'h8,
    ST_RF_END   = 4'h9
  } state_e;

  state_e                 state;
  logic                   timer_load;
  logic [TIMER_W-1:0]     timer_count;
  logic                   timer_done;
  logic [TIMER_W-1:0]     refresh_ctr;
  logic                   refresh_due;
  logic [3:0]             init_left;
  logic [8:0]             ror_row;
  logic                   cur_write;
  logic [ADDR_W-1:0]      cur_addr;
  logic                   data_meta;
  logic                   data_sync;

  // ----------------------------------------------------------------
  // Shared delay timer
  // ----------------------------------------------------------------
  // One timer serves every wait; the states never overlap, so sharing is safe
  cycle_timer #(
    .WIDTH (TIMER_W)
  ) u_timer (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (timer_load),
    .count_i   (timer_count),
    .done_o    (timer_done)
  );

  // Size-cast a cycle count onto the timer's load width; widths checked above
  function automatic logic [TIMER_W-1:0] tc(input int unsigned n);
    return TIMER_W'(n);
  endfunction

  // ----------------------------------------------------------------
  // Input synchroniser for the asynchronous data-out pin
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_meta <= 1'b0;
      data_sync <= 1'b0;
    end else begin
      // Only the second stage feeds logic; the first may be metastable
      data_meta <= data_out_i;
      data_sync <= data_meta;
    end
  end

  // ----------------------------------------------------------------
  // Refresh interval counter
  // ----------------------------------------------------------------
  // One row per slot keeps all 512 rows inside the interval
  // The slot counter runs from reset, so the first periodic refresh may come
  // early; an early refresh costs a few cycles and never starves a row
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      refresh_ctr <= '0;
      refresh_due <= 1'b0;
    end else begin
      if (refresh_ctr == tc(REFRESH_CYCLES - 1)) begin
        refresh_ctr <= '0;
      end else begin
        refresh_ctr <= refresh_ctr + 1'b1;
      end
      // Set wins over clear when both land in one cycle
      if (refresh_ctr == tc(REFRESH_CYCLES - 1) && init_done_o) begin
        refresh_due <= 1'b1;
      end else if (state == ST_RF_END) begin
        refresh_due <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequencer
  // ----------------------------------------------------------------
  // Refresh is checked before requests in idle and between accesses
  // Every pin output here is a flop, so the pins change only on clock edges
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state       <= ST_POWERUP;
      timer_load  <= 1'b1;
      timer_count <= '0;
      init_left   <= 4'h8;
      init_done_o <= 1'b0;
      ror_row     <= '0;
      cur_write   <= 1'b0;
      cur_addr    <= '0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 1'b0;
      row_strobe_n_o   <= 1'b1;
      col_strobe_n_o   <= 1'b1;
      write_strobe_n_o <= 1'b1;
      multiplexed_address_pins_o <= '0;
      data_in_o   <= 1'b0;
    end else begin
      timer_load  <= 1'b0;
      rsp_valid_o <= 1'b0;
      case (state)
        ST_POWERUP: begin
          // A reset in mid-run returns here, so pause and init refreshes repeat
          if (timer_count == '0) begin
            timer_load  <= 1'b1;
            timer_count <= tc(POWERUP_CYCLES);
          end else if (timer_done && !timer_load) begin
            state <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (!init_done_o || refresh_due) begin
            // Eight init refreshes, then periodic ones
            if (USE_CBR) begin
              col_strobe_n_o <= 1'b0;
              timer_load     <= 1'b1;
              timer_count    <= tc(COL_PRE_CYC);
              state          <= ST_RF_CAS;
            end else begin
              // Row-only refresh: next row on the pins, column strobe stays high
              multiplexed_address_pins_o <= {1'b0, ror_row};
              timer_load     <= 1'b1;
              timer_count    <= tc(1);
              state          <= ST_RF_CAS;
            end
          end else if (req_valid_i) begin
            // Row half first, set up before the row strobe falls
            cur_write <= req_write_i;
            cur_addr  <= req_addr_i;
            multiplexed_address_pins_o <= req_addr_i[ADDR_W-1:PIN_W];
            // Data-in follows the request even for reads; the memory ignores it then
            data_in_o <= req_wdata_i;
            write_strobe_n_o <= !req_write_i;
            state     <= ST_ROW;
          end
        end
        ST_ROW: begin
          // Row half has had a full cycle of set-up on the pins
          row_strobe_n_o <= 1'b0;
          timer_load     <= 1'b1;
          timer_count    <= tc(ROW_HOLD_CYC);
          state          <= ST_COL;
        end
        ST_COL: begin
          if (timer_done && !timer_load) begin
            // Column half after row hold; the flow-through latch takes it now
            multiplexed_address_pins_o <= cur_addr[PIN_W-1:0];
            state <= ST_ACCESS;
            timer_load  <= 1'b1;
            timer_count <= tc(1);
          end
        end
        ST_ACCESS: begin
          // Read wait covers the slower column access path and the two
          // synchroniser stages, so the captured bit is the settled one
          if (col_strobe_n_o && timer_done && !timer_load) begin
            col_strobe_n_o <= 1'b0;
            timer_load     <= 1'b1;
            timer_count    <= tc(cur_write ? DATA_HOLD_CYC : READ_WAIT_CYC);
          end else if (!col_strobe_n_o && timer_done && !timer_load) begin
            if (!cur_write) begin
              rsp_rdata_o <= data_sync;
            end
            rsp_valid_o    <= 1'b1;
            col_strobe_n_o <= 1'b1;
            write_strobe_n_o <= 1'b1;
            timer_load     <= 1'b1;
            timer_count    <= tc(ROW_PULSE_CYC);
            state          <= ST_PRECHG;
          end
        end
        ST_PRECHG: begin
          if (row_strobe_n_o == 1'b0 && timer_done && !timer_load) begin
            row_strobe_n_o <= 1'b1;
            timer_load     <= 1'b1;
            timer_count    <= tc(PRECHARGE_CYC);
          end else if (row_strobe_n_o && timer_done && !timer_load) begin
            // Accesses are spaced by a full precharge, far slower than the
            // fast column rate; this controller never issues fast column cycles
            state <= ST_IDLE;
          end
        end
        ST_RF_CAS: begin
          if (timer_done && !timer_load) begin
            // Column strobe has met its set-up; the row strobe starts the refresh
            row_strobe_n_o <= 1'b0;
            timer_load     <= 1'b1;
            timer_count    <= tc(ROW_PULSE_CYC);
            state          <= ST_RF_RAS;
          end
        end
        ST_RF_RAS: begin
          if (timer_done && !timer_load) begin
            row_strobe_n_o <= 1'b1;
            col_strobe_n_o <= 1'b1;
            // Row counter only steers row-only refresh; the memory counts its own
            ror_row        <= ror_row + 1'b1;
            timer_load     <= 1'b1;
            timer_count    <= tc(PRECHARGE_CYC);
            state          <= ST_RF_END;
          end
        end
        ST_RF_END: begin
          if (timer_done && !timer_load) begin
            if (!init_done_o) begin
              // Last init refresh opens the request path
              if (init_left == 4'h1) begin
                init_done_o <= 1'b1;
              end
              init_left <= init_left - 1'b1;
            end
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Request handshake
  // ----------------------------------------------------------------
  // Ready only in idle with no refresh owed; refresh goes first
  assign req_ready_o = (state == ST_IDLE) && init_done_o && !refresh_due;

endmodule

// File: dram_ctrl_pkg.sv
// Purpose: Shared constants for the 1M x 1 DRAM controller.
// Assumes: 100 MHz controller clock.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package dram_ctrl_pkg;

  // ----------------------------------------------------------------
  // Clock and geometry
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS  = 10000;
  localparam int unsigned ADDR_W         = 20;
  localparam int unsigned PIN_W          = 10;
  localparam int unsigned REFRESH_ROWS   = 512;
  localparam int unsigned INIT_CYCLES    = 8;

  // ----------------------------------------------------------------
  // Timing figures (ns and us as printed)
  // ----------------------------------------------------------------
  localparam int unsigned ROW_STROBE_ACCESS_NS    = 70;
  localparam int unsigned COL_STROBE_ACCESS_NS    = 20;
  localparam int unsigned COL_ADDR_ACCESS_NS      = 35;
  localparam int unsigned ROW_ADDR_HOLD_NS        = 10;
  localparam int unsigned ROW_PRECHARGE_NS        = 60;
  localparam int unsigned ROW_PULSE_NS            = 70;
  localparam int unsigned COL_PRECHARGE_NS        = 20;
  localparam int unsigned FAST_COL_CYCLE_NS       = 40;
  localparam int unsigned DATA_HOLD_NS            = 10;
  localparam int unsigned POWERUP_PAUSE_US        = 200;
  localparam int unsigned REFRESH_INTERVAL_US     = 8200;

  // Least times round up
  function automatic int unsigned ns_to_cyc_up(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest times round down
  function automatic int unsigned ns_to_cyc_dn(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned ROW_ACCESS_CYC   = ns_to_cyc_up(ROW_STROBE_ACCESS_NS);
  localparam int unsigned COL_ACCESS_CYC   = ns_to_cyc_up(COL_STROBE_ACCESS_NS);
  localparam int unsigned ADDR_ACCESS_CYC  = ns_to_cyc_up(COL_ADDR_ACCESS_NS);
  localparam int unsigned ROW_HOLD_CYC     = ns_to_cyc_up(ROW_ADDR_HOLD_NS);
  localparam int unsigned PRECHARGE_CYC    = ns_to_cyc_up(ROW_PRECHARGE_NS);
  localparam int unsigned ROW_PULSE_CYC    = ns_to_cyc_up(ROW_PULSE_NS);
  localparam int unsigned COL_PRE_CYC      = ns_to_cyc_up(COL_PRECHARGE_NS);
  localparam int unsigned FAST_COL_CYC     = ns_to_cyc_up(FAST_COL_CYCLE_NS);
  localparam int unsigned DATA_HOLD_CYC    = ns_to_cyc_up(DATA_HOLD_NS);
  localparam int unsigned POWERUP_CYC      = ns_to_cyc_up(POWERUP_PAUSE_US * 1000);
  // Refresh one row per slot: interval spread evenly over all rows, rounded down
  localparam int unsigned REFRESH_SLOT_CYC =
    ns_to_cyc_dn(REFRESH_INTERVAL_US * 1000 / REFRESH_ROWS);

  // Stages between the data-out pin and the capture flop
  localparam int unsigned SYNC_STAGES = 2;
  // Access wait after column strobe falls: longest applicable of the three,
  // plus the synchroniser, or the capture would see the bit before it settles
  localparam int unsigned READ_WAIT_CYC =
    ((COL_ACCESS_CYC > ADDR_ACCESS_CYC) ? COL_ACCESS_CYC : ADDR_ACCESS_CYC) + SYNC_STAGES;

  localparam int unsigned TIMER_W = 16;

endpackage

// File: dram_ctrl_props.sv
// Purpose: Pin-level checks on the DRAM controller.
// Assumes: One clock domain; reset active low.
// Notes:   Refresh gap slack covers one access in progress.
module dram_ctrl_props
  import dram_ctrl_pkg::*;
#(
  parameter int unsigned POWERUP_CYCLES = POWERUP_CYC,
  parameter int unsigned REFRESH_CYCLES = REFRESH_SLOT_CYC
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic              req_wdata_i,
  input  wire logic              rsp_valid_o,
  input  wire logic              rsp_rdata_o,
  input  wire logic              init_done_o,
  input  wire logic              row_strobe_n_o,
  input  wire logic              col_strobe_n_o,
  input  wire logic              write_strobe_n_o,
  input  wire logic [PIN_W-1:0]  multiplexed_address_pins_o,
  input  wire logic              data_in_o,
  input  wire logic              data_out_i
);
  int unsigned boot_cyc;
  int unsigned cbr_gap;
  int unsigned init_falls;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Cycles since reset, since the last internal refresh, and row falls
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_cyc   <= 0;
      cbr_gap    <= 0;
      init_falls <= 0;
    end else begin
      boot_cyc   <= (boot_cyc < POWERUP_CYCLES) ? boot_cyc + 1 : boot_cyc;
      cbr_gap    <= ($fell(row_strobe_n_o) && !col_strobe_n_o) ? 0 : cbr_gap + 1;
      init_falls <= ($fell(row_strobe_n_o) && init_falls < 15) ? init_falls + 1 : init_falls;
    end
  end

  sequence cas_fall_s;
    $fell(col_strobe_n_o) && !row_strobe_n_o;
  endsequence
  sequence taken_s;
    req_valid_i && req_ready_o;
  endsequence

  pause_idle_a: assert property (boot_cyc < POWERUP_CYCLES |-> row_strobe_n_o && col_strobe_n_o)
    else $error("strobe active during power-up pause");
  init_count_a: assert property ($rose(init_done_o) |-> init_falls >= INIT_CYCLES)
    else $error("too few refresh cycles before init done");
  ready_init_a: assert property (!init_done_o |-> !req_ready_o)
    else $error("request accepted before init done");
  row_addr_a: assert property ($fell(row_strobe_n_o) && col_strobe_n_o |-> $stable(multiplexed_address_pins_o))
    else $error("address moved at row strobe fall");
  col_addr_a: assert property (cas_fall_s |-> $stable(multiplexed_address_pins_o))
    else $error("address moved at column strobe fall");
  early_write_a: assert property (cas_fall_s ##0 !write_strobe_n_o |->
    !$past(write_strobe_n_o) && $stable(data_in_o) ##1 $stable(data_in_o) && !write_strobe_n_o)
    else $error("early write set-up or hold broken");
  read_wait_a: assert property (cas_fall_s ##0 write_strobe_n_o |-> (!col_strobe_n_o && write_strobe_n_o)[*4])
    else $error("read column strobe shorter than access time");
  cbr_setup_a: assert property ($fell(row_strobe_n_o) && !col_strobe_n_o |-> !$past(col_strobe_n_o))
    else $error("column strobe not set up before internal refresh");
  refresh_gap_a: assert property (init_done_o |-> cbr_gap <= REFRESH_CYCLES + 40)
    else $error("refresh slot overrun");
  answer_time_a: assert property (taken_s |-> ##[8:20] rsp_valid_o)
    else $error("no response within bound");
endmodule

bind dram_ctrl dram_ctrl_props #(
  .POWERUP_CYCLES(POWERUP_CYCLES),
  .REFRESH_CYCLES(REFRESH_CYCLES)
) i_props (
  .ref_clk_i, .rst_n_i, .req_valid_i, .req_ready_o, .req_write_i, .req_addr_i,
  .req_wdata_i, .rsp_valid_o, .rsp_rdata_o, .init_done_o, .row_strobe_n_o,
  .col_strobe_n_o, .write_strobe_n_o, .multiplexed_address_pins_o, .data_in_o,
  .data_out_i
);

// File: dram_model.sv
// Purpose: Behavioural 1M x 1 DRAM on the controller's pins.
// Assumes: Strobes active low; memory starts cleared.
// Notes:   A released data-out shows the inverse of its last level.
module dram_model
  import dram_ctrl_pkg::*;
(
  input  wire logic             row_strobe_n_i,
  input  wire logic             col_strobe_n_i,
  input  wire logic             write_strobe_n_i,
  input  wire logic [PIN_W-1:0] multiplexed_address_pins_i,
  input  wire logic             data_in_i,
  output logic                  data_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  bit               mem [2**ADDR_W];
  logic [PIN_W-1:0] row;
  logic [PIN_W-1:0] col;
  logic [8:0]       cbr_row = '0;
  int               refresh_count = 0;

  // ----------------------------------------------------------------
  // Strobe handling
  // ----------------------------------------------------------------
  initial data_out_o = 1'h0;
  // Column low first means internal refresh; else latch the row
  always @(negedge row_strobe_n_i) begin
    refresh_count++;
    if (!col_strobe_n_i) begin
      cbr_row <= cbr_row + 9'h1;
    end else begin
      row = multiplexed_address_pins_i;
    end
  end
  // Early write latches data here; a read is valid only after access time
  always @(negedge col_strobe_n_i) begin
    if (!row_strobe_n_i) begin
      col = multiplexed_address_pins_i;
      if (!write_strobe_n_i) begin
        mem[{row, col}] = data_in_i;
      end else begin
        data_out_o = ~mem[{row, col}];
        #(COL_ADDR_ACCESS_NS);
        data_out_o = mem[{row, col}];
      end
    end
  end
  // Write strobe falling after the column strobe latches data itself
  always @(negedge write_strobe_n_i) begin
    if (!row_strobe_n_i && !col_strobe_n_i) begin
      mem[{row, col}] = data_in_i;
    end
  end
  // Released output must not look like held data
  always @(posedge col_strobe_n_i) begin
    data_out_o = ~data_out_o;
  end
endmodule

// File: tb_top.sv
// Purpose: Self-checking bench for the DRAM controller.
// Assumes: Short power-up and refresh counts for simulation.
// Notes:   Reads drive the inverse bit on write data; it must be ignored.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dram_ctrl_pkg::*;

  localparam int unsigned PAUSE = 50;
  localparam int unsigned SLOT  = 200;
  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic              val;
  } op_s;
  // Writes then read-backs at corners of row and column halves
  localparam op_s OPS [12] = '{
    '{1'h1, 20'h00000, 1'h1}, '{1'h1, 20'hfffff, 1'h1}, '{1'h1, 20'h003ff, 1'h1},
    '{1'h1, 20'h00400, 1'h1}, '{1'h1, 20'h00400, 1'h0}, '{1'h1, 20'haaaaa, 1'h1},
    '{1'h1, 20'h55555, 1'h1}, '{1'h0, 20'h00000, 1'h1}, '{1'h0, 20'hfffff, 1'h1},
    '{1'h0, 20'h003ff, 1'h1}, '{1'h0, 20'h00400, 1'h0}, '{1'h0, 20'h55555, 1'h1}};

  logic              ref_clk, rst_n, req_valid, req_write, req_wdata, got;
  logic [ADDR_W-1:0] req_addr;
  logic              req_ready, rsp_valid, rsp_rdata, init_done, row_n, col_n, we_n, din, dout;
  logic [PIN_W-1:0]  pins;
  int                fail_count = 0;
  int                samples_checked = 0;
  int                cycles = 0;
  int                base;

  dram_ctrl #(.POWERUP_CYCLES(PAUSE), .REFRESH_CYCLES(SLOT), .USE_CBR(1'h1)) i_dut (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .req_valid_i(req_valid), .req_ready_o(req_ready),
    .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .rsp_valid_o(rsp_valid), .rsp_rdata_o(rsp_rdata), .init_done_o(init_done),
    .row_strobe_n_o(row_n), .col_strobe_n_o(col_n), .write_strobe_n_o(we_n),
    .multiplexed_address_pins_o(pins), .data_in_o(din), .data_out_i(dout));
  dram_model i_mem (
    .row_strobe_n_i(row_n), .col_strobe_n_i(col_n), .write_strobe_n_i(we_n),
    .multiplexed_address_pins_i(pins), .data_in_i(din), .data_out_o(dout));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check_bit(input string what, input logic exp, input logic seen);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic check_min(input string what, input int exp, input int seen);
    samples_checked++;
    if (seen < exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected at least %0d seen %0d", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Release reset; bounded wait for the power-up sequence
  task automatic bring_up();
    base = i_mem.refresh_count;
    rst_n = 1'h1;
    for (int n = 0; n < 3000 && init_done !== 1'h1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check_bit("init done", 1'h1, init_done);
    check_min("init refreshes", INIT_CYCLES, i_mem.refresh_count - base);
  endtask
  // One request held until taken, then a bounded wait for the response
  task automatic access(input op_s op);
    req_valid = 1'h1;
    req_write = op.wr;
    req_addr  = op.addr;
    req_wdata = op.wr ? op.val : ~op.val;
    for (int n = 0; n < 500 && req_ready !== 1'h1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    req_valid = 1'h0;
    for (int n = 0; n < 40 && rsp_valid !== 1'h1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    check_bit("response", 1'h1, rsp_valid);
    got = rsp_rdata;
    @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Clock, hang guard and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Whole run needs about 2800 cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    rst_n = 1'h0;
    req_valid = 1'h0;
    req_write = 1'h0;
    req_addr = '0;
    req_wdata = 1'h0;
    repeat (20) @(posedge ref_clk);
    #1;
    check_bit("row strobe in reset", 1'h1, row_n);
    bring_up();
    $display("test power-up done");
    foreach (OPS[i]) begin
      access(OPS[i]);
      if (OPS[i].wr === 1'h0) begin
        check_bit("read bit", OPS[i].val, got);
      end
    end
    $display("test table done");
    base = i_mem.refresh_count;
    repeat (2000) @(posedge ref_clk);
    #1;
    check_min("idle refreshes", 2000 / SLOT - 1, i_mem.refresh_count - base);
    $display("test refresh done");
    req_valid = 1'h1;
    req_write = 1'h1;
    req_addr = 20'h00000;
    repeat (5) @(posedge ref_clk);
    #1;
    rst_n = 1'h0;
    req_valid = 1'h0;
    @(posedge ref_clk);
    #1;
    check_bit("row strobe in reset", 1'h1, row_n);
    check_bit("ready in reset", 1'h0, req_ready);
    bring_up();
    access('{1'h0, 20'haaaaa, 1'h1});
    check_bit("read after reset", 1'h1, got);
    $display("test reset done");
    complete_run();
  end
endmodule
